//--- core/core_instruction_decode_timing.sv
// Instruction decoder and four-phase instruction cycle sequencer
`timescale 1ns/100ps
`include "decode_params.svh"

// Overview of operation
// RQ1 - Each instruction is one 14-bit word: opcode plus operand fields.
// RQ2 - Byte ops: d=0 result to accumulator, d=1 back to file register.
// RQ3 - File selector addresses register file 0x00 to 0x7F.
// RQ4 - Bit ops: bit field picks one bit of the selected 8-bit register.
// RQ5 - Literal/control ops extract an 8-bit or 11-bit constant.
// RQ6 - One instruction cycle lasts exactly four oscillator periods.
// RQ7 - One cycle normally; taken test or PC change adds a no-operation cycle.
// RQ8 - File operands are read, modified, stored; read happens even on pure writes.
// RQ9 - Don't-care bits are ignored by the decoder.
// RQ10 - Read before port clear has normal port read side effects.
// RQ11 - Port read-modify-write uses pin levels, not output latches.
// RQ12 - Writing timer-zero count clears its prescaler when assigned to it.
// RQ13 - Add-literal adds the 8-bit literal to the accumulator.
// RQ14 - Two-cycle ops discard the prefetch and refetch during the no-op cycle.
// RQ15 - Class comes from leading opcode bits before operand extraction.
module core_instruction_decode_timing (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [13:0] prog_word,
  input wire logic test_true,
  input wire logic prescaler_to_timer,
  input wire logic [7:0] acc_in,
  output logic [1:0] phase,
  output logic cycle_end,
  output decode_pkg::decoded_t dec,
  output logic exec_nop,
  output logic fetch_strobe,
  output logic fetch_redirect,
  output logic file_read,
  output logic read_from_pins,
  output logic porta_change_clear,
  output logic file_write,
  output logic acc_write,
  output logic tmr0_prescaler_clear,
  output logic [7:0] acc_sum
);
  // ========================================================================
  // Phase counter
  logic [1:0] next_phase;
  always_comb begin
    // RQ6 four periods
    next_phase = (phase == `DEC_Q_LAST) ? 2'h0 : 2'(phase + 2'h1);
    if (!rst_n) begin
      next_phase = 2'h0;
    end
  end
  always_ff @(posedge clk) begin
    phase <= next_phase;
  end
  assign cycle_end = (phase == `DEC_Q_LAST);

  // ========================================================================
  // Word decode
  decode_pkg::decoded_t word_dec;
  always_comb begin
    word_dec = '0;
    // RQ1 fixed fields
    word_dec.file_addr = prog_word[6:0];
    word_dec.dest_file = prog_word[`DEC_DEST_BIT];
    word_dec.bit_pos = prog_word[9:7];
    // RQ5 literal fields
    word_dec.lit8 = prog_word[7:0];
    word_dec.lit11 = prog_word[10:0];
    word_dec.op = decode_pkg::OP_NOP;
    // RQ15 class first
    unique case (prog_word[`DEC_CLASS_HI:`DEC_CLASS_LO])
      2'b00: word_dec.cls = decode_pkg::CLS_BYTE;
      2'b01: word_dec.cls = decode_pkg::CLS_BIT;
      default: word_dec.cls = decode_pkg::CLS_LITCTL;
    endcase
    // RQ9 wildcards for don't-care bits
    casez (prog_word)
      14'b00_0000_1???_????: word_dec.op = decode_pkg::OP_MOVWF;
      14'b00_0000_0000_1000: word_dec.op = decode_pkg::OP_RETURN;
      14'b00_0000_0000_1001: word_dec.op = decode_pkg::OP_RETFIE;
      14'b00_0000_0110_0011: word_dec.op = decode_pkg::OP_SLEEP;
      14'b00_0000_0110_0100: word_dec.op = decode_pkg::OP_CLRWDT;
      14'b00_0001_1???_????: word_dec.op = decode_pkg::OP_WIPE;
      14'b00_0001_0???_????: word_dec.op = decode_pkg::OP_CLRW;
      14'b00_0010_????_????: word_dec.op = decode_pkg::OP_SUBWF;
      14'b00_0011_????_????: word_dec.op = decode_pkg::OP_DECF;
      14'b00_0100_????_????: word_dec.op = decode_pkg::OP_IORWF;
      14'b00_0101_????_????: word_dec.op = decode_pkg::OP_ANDWF;
      14'b00_0110_????_????: word_dec.op = decode_pkg::OP_XORWF;
      14'b00_0111_????_????: word_dec.op = decode_pkg::OP_ADDWF;
      14'b00_1000_????_????: word_dec.op = decode_pkg::OP_MOVF;
      14'b00_1001_????_????: word_dec.op = decode_pkg::OP_COMF;
      14'b00_1010_????_????: word_dec.op = decode_pkg::OP_INCF;
      14'b00_1011_????_????: word_dec.op = decode_pkg::OP_DECFSZ;
      14'b00_1100_????_????: word_dec.op = decode_pkg::OP_RRF;
      14'b00_1101_????_????: word_dec.op = decode_pkg::OP_RLF;
      14'b00_1110_????_????: word_dec.op = decode_pkg::OP_SWAPF;
      14'b00_1111_????_????: word_dec.op = decode_pkg::OP_INCFSZ;
      14'b01_00??_????_????: word_dec.op = decode_pkg::OP_BCF;
      14'b01_01??_????_????: word_dec.op = decode_pkg::OP_BSF;
      14'b01_10??_????_????: word_dec.op = decode_pkg::OP_BTFSC;
      14'b01_11??_????_????: word_dec.op = decode_pkg::OP_BTFSS;
      14'b10_0???_????_????: word_dec.op = decode_pkg::OP_CALL;
      14'b10_1???_????_????: word_dec.op = decode_pkg::OP_GOTO;
      14'b11_00??_????_????: word_dec.op = decode_pkg::OP_MOVLW;
      14'b11_01??_????_????: word_dec.op = decode_pkg::OP_RETLW;
      14'b11_1000_????_????: word_dec.op = decode_pkg::OP_IORLW;
      14'b11_1001_????_????: word_dec.op = decode_pkg::OP_ANDLW;
      14'b11_1010_????_????: word_dec.op = decode_pkg::OP_XORLW;
      14'b11_110?_????_????: word_dec.op = decode_pkg::OP_SUBLW;
      14'b11_111?_????_????: word_dec.op = decode_pkg::OP_ADDLW;
      // Unlisted codes, plain no-operation included, execute as no-op
      default: word_dec.op = decode_pkg::OP_NOP;
    endcase
  end

  // ========================================================================
  // Executing instruction properties
  logic is_skip;
  logic pc_change;
  logic two_cycle;
  logic file_op;
  logic byte_alu;
  always_comb begin
    is_skip = (dec.op == decode_pkg::OP_DECFSZ) || (dec.op == decode_pkg::OP_INCFSZ) ||
      (dec.op == decode_pkg::OP_BTFSC) || (dec.op == decode_pkg::OP_BTFSS);
    pc_change = (dec.op == decode_pkg::OP_CALL) || (dec.op == decode_pkg::OP_GOTO) ||
      (dec.op == decode_pkg::OP_RETURN) || (dec.op == decode_pkg::OP_RETFIE) ||
      (dec.op == decode_pkg::OP_RETLW);
    // RQ7 taken test or jump
    two_cycle = !exec_nop && (pc_change || (is_skip && test_true));
    file_op = !exec_nop && (dec.cls != decode_pkg::CLS_LITCTL) &&
      (dec.op != decode_pkg::OP_NOP) && (dec.op != decode_pkg::OP_CLRW) &&
      (dec.op != decode_pkg::OP_RETURN) && (dec.op != decode_pkg::OP_RETFIE) &&
      (dec.op != decode_pkg::OP_SLEEP) && (dec.op != decode_pkg::OP_CLRWDT);
    byte_alu = file_op && (dec.cls == decode_pkg::CLS_BYTE) &&
      (dec.op != decode_pkg::OP_MOVWF) && (dec.op != decode_pkg::OP_WIPE);
  end

  // ========================================================================
  // Instruction register and fetch control
  decode_pkg::decoded_t next_dec;
  logic next_exec_nop;
  always_comb begin
    next_dec = dec;
    next_exec_nop = exec_nop;
    if (cycle_end) begin
      next_dec = word_dec;
      // RQ14 prefetch dropped
      next_exec_nop = two_cycle;
    end
    if (!rst_n) begin
      next_dec = '0;
      next_exec_nop = 1'b1;
    end
  end
  always_ff @(posedge clk) begin
    dec <= next_dec;
    exec_nop <= next_exec_nop;
  end
  assign fetch_strobe = cycle_end;
  // RQ14 refetch from target
  assign fetch_redirect = cycle_end && two_cycle;

  // ========================================================================
  // Read-modify-write strobes
  logic is_port;
  // RQ3 seven-bit selector
  assign is_port = (dec.file_addr >= `DEC_PORT_FIRST) && (dec.file_addr <= `DEC_PORT_LAST);
  // RQ8 read always precedes store
  assign file_read = file_op && (phase == `DEC_Q_READ);
  // RQ11 pins feed port modify
  assign read_from_pins = file_read && is_port;
  // RQ10 clear also reads port
  assign porta_change_clear = file_read && (dec.file_addr == `DEC_PORTA_ADDR);
  // RQ2 destination select
  // RQ4 bit set/clear ops write back; bit test ops do not
  assign file_write = cycle_end && file_op && (dec.op != decode_pkg::OP_BTFSC) &&
    (dec.op != decode_pkg::OP_BTFSS) && (!byte_alu || dec.dest_file);
  assign acc_write = cycle_end && !exec_nop && ((byte_alu && !dec.dest_file) ||
    (dec.op == decode_pkg::OP_CLRW) || (dec.op == decode_pkg::OP_RETLW) ||
    ((dec.cls == decode_pkg::CLS_LITCTL) && (dec.op >= decode_pkg::OP_MOVLW) &&
    (dec.op <= decode_pkg::OP_ADDLW)));
  // RQ12 timer write clears prescaler
  assign tmr0_prescaler_clear = file_write && (dec.file_addr == `DEC_TMR0_ADDR) && prescaler_to_timer;

  // ========================================================================
  // Add-literal sum
  logic [7:0] next_acc_sum;
  always_comb begin
    next_acc_sum = acc_sum;
    // RQ13 literal plus accumulator
    // Discarded prefetch must not touch the sum
    if ((phase == `DEC_Q_MODIFY) && !exec_nop && (dec.op == decode_pkg::OP_ADDLW)) begin
      next_acc_sum = 8'(acc_in + dec.lit8);
    end
    if (!rst_n) begin
      next_acc_sum = 8'h00;
    end
  end
  always_ff @(posedge clk) begin
    acc_sum <= next_acc_sum;
  end

  // ========================================================================
  // Checks
  property p_cycle_four;
    @(posedge clk) disable iff (!rst_n) cycle_end |=> !cycle_end [*3] ##1 cycle_end;
  endproperty
  a_cycle_four: assert property (p_cycle_four) else $error("cycle not four periods"); // RQ6

  property p_read_first;
    @(posedge clk) disable iff (!rst_n) file_write |-> $past(file_read, 2);
  endproperty
  a_read_first: assert property (p_read_first) else $error("store without prior read"); // RQ8

  property p_nop_after_jump;
    @(posedge clk) disable iff (!rst_n) fetch_redirect |=> exec_nop [*4];
  endproperty
  a_nop_after_jump: assert property (p_nop_after_jump) else $error("second cycle not no-op"); // RQ7

  property p_dest_acc;
    @(posedge clk) disable iff (!rst_n)
      (cycle_end && byte_alu) |-> (file_write == dec.dest_file) && (acc_write == !dec.dest_file);
  endproperty
  a_dest_acc: assert property (p_dest_acc) else $error("wrong destination"); // RQ2

  property p_lit11;
    @(posedge clk) disable iff (!rst_n)
      (cycle_end && (prog_word[13:12] == 2'b10)) |=> dec.lit11 == $past(prog_word[10:0]);
  endproperty
  a_lit11: assert property (p_lit11) else $error("long literal mismatch"); // RQ5

  property p_bit_pos;
    @(posedge clk) disable iff (!rst_n)
      (cycle_end && (prog_word[13:12] == 2'b01)) |=> (dec.cls == decode_pkg::CLS_BIT) &&
      (dec.bit_pos == $past(prog_word[9:7])) && (dec.file_addr == $past(prog_word[6:0]));
  endproperty
  a_bit_pos: assert property (p_bit_pos) else $error("bit operand mismatch"); // RQ4

  property p_porta_clear;
    @(posedge clk) disable iff (!rst_n)
      (file_read && (dec.file_addr == `DEC_PORTA_ADDR)) |-> porta_change_clear && read_from_pins;
  endproperty
  a_porta_clear: assert property (p_porta_clear) else $error("port read effect missing"); // RQ10

  property p_tmr0;
    @(posedge clk) disable iff (!rst_n)
      tmr0_prescaler_clear |-> file_write && prescaler_to_timer && $past(file_read, 2);
  endproperty
  a_tmr0: assert property (p_tmr0) else $error("bad prescaler clear"); // RQ12

  property p_addlw;
    @(posedge clk) disable iff (!rst_n)
      (acc_write && (dec.op == decode_pkg::OP_ADDLW)) |-> acc_sum == 8'($past(acc_in) + dec.lit8);
  endproperty
  a_addlw: assert property (p_addlw) else $error("add literal sum wrong"); // RQ13
endmodule : core_instruction_decode_timing

//--- core/decode_params.svh
// Constants for the instruction decode and timing block
`ifndef DECODE_PARAMS_SVH
`define DECODE_PARAMS_SVH
// ==========================================================================
// Timing
`define DEC_PERIODS_PER_CYCLE 4
`define DEC_Q_LAST 2'h3
`define DEC_Q_READ 2'h1
`define DEC_Q_MODIFY 2'h2
// ==========================================================================
// Field positions
`define DEC_CLASS_HI 13
`define DEC_CLASS_LO 12
`define DEC_DEST_BIT 7
`define DEC_NOP_WORD 14'h0000
// ==========================================================================
// Special file addresses
`define DEC_TMR0_ADDR 7'h01
`define DEC_PORTA_ADDR 7'h05
`define DEC_PORT_FIRST 7'h05
`define DEC_PORT_LAST 7'h09
`endif

//--- core/decode_pkg.sv
// Types shared by the instruction decode and timing block
package decode_pkg;
  // ========================================================================
  // Instruction classes and operations
  typedef enum logic [1:0] {CLS_BYTE, CLS_BIT, CLS_LITCTL} class_t;
  typedef enum logic [5:0] {
    OP_NOP, OP_MOVWF, OP_WIPE, OP_CLRW, OP_SUBWF, OP_DECF, OP_IORWF, OP_ANDWF,
    OP_XORWF, OP_ADDWF, OP_MOVF, OP_COMF, OP_INCF, OP_DECFSZ, OP_RRF, OP_RLF,
    OP_SWAPF, OP_INCFSZ, OP_BCF, OP_BSF, OP_BTFSC, OP_BTFSS, OP_CALL, OP_GOTO,
    OP_MOVLW, OP_RETLW, OP_IORLW, OP_ANDLW, OP_XORLW, OP_SUBLW, OP_ADDLW,
    OP_RETURN, OP_RETFIE, OP_SLEEP, OP_CLRWDT
  } op_t;
  // ========================================================================
  // Decoded instruction
  typedef struct packed {
    class_t cls;
    op_t op;
    logic [6:0] file_addr;
    logic dest_file;
    logic [2:0] bit_pos;
    logic [7:0] lit8;
    logic [10:0] lit11;
  } decoded_t;
endpackage : decode_pkg

//--- tb/prog_source.sv
// Program memory model that feeds the prefetch path
`timescale 1ns/100ps
module prog_source (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic fetch_strobe,
  output logic [13:0] prog_word
);
  // ==========================================================================
  // Storage and fetch pointer
  logic [13:0] rom [0:15];
  logic [3:0] pc;
  assign prog_word = rom[pc];
  // Sequential only: programs place skip targets right after the slot
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pc <= 4'h0;
    end else if (fetch_strobe) begin
      pc <= pc + 4'h1;
    end
  end
endmodule : prog_source

//--- tb/core_instruction_decode_timing_bench.sv
// Self-checking bench for the instruction decode and timing block
`timescale 1ns/100ps
module core_instruction_decode_timing_bench;
  // ==========================================================================
  // Signals
  logic clk;
  logic rst_n;
  logic [13:0] prog_word;
  logic test_true;
  logic prescaler_to_timer;
  logic [7:0] acc_in;
  logic [1:0] phase;
  logic cycle_end;
  decode_pkg::decoded_t dec;
  logic exec_nop;
  logic fetch_strobe;
  logic fetch_redirect;
  logic file_read;
  logic read_from_pins;
  logic porta_change_clear;
  logic file_write;
  logic acc_write;
  logic tmr0_prescaler_clear;
  logic [7:0] acc_sum;
  int err_total;
  int comparisons;
  // Slots after a taken skip or jump hold words that must be dropped
  localparam logic [13:0] PROG [0:15] = '{14'h0785, 14'h0185, 14'h0807, 14'h0081, 14'h3F3C, 14'h16A0,
    14'h1FFF, 14'h0185, 14'h2FFF, 14'h0785, 14'h017F, 14'h1800, 14'h0000, 14'h0000, 14'h0000, 14'h0000};
  // ==========================================================================
  // Instances
  core_instruction_decode_timing i_dut (.clk(clk), .rst_n(rst_n), .prog_word(prog_word),
    .test_true(test_true), .prescaler_to_timer(prescaler_to_timer), .acc_in(acc_in), .phase(phase),
    .cycle_end(cycle_end), .dec(dec), .exec_nop(exec_nop), .fetch_strobe(fetch_strobe),
    .fetch_redirect(fetch_redirect), .file_read(file_read), .read_from_pins(read_from_pins),
    .porta_change_clear(porta_change_clear), .file_write(file_write), .acc_write(acc_write),
    .tmr0_prescaler_clear(tmr0_prescaler_clear), .acc_sum(acc_sum));
  prog_source i_mem (.clk(clk), .rst_n(rst_n), .fetch_strobe(fetch_strobe), .prog_word(prog_word));
  always #20 clk = ~clk;
  // ==========================================================================
  // Shared tasks
  task automatic test_done();
    $display("counts: %0d mismatches in %0d comparisons", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : test_done
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  // One instruction cycle: strobes packed as nop,rd,pins,clr,wr,acc,redir,tmr
  task automatic step(input logic [7:0] exp, input logic tt);
    logic [7:0] v;
    logic [3:0] ce;
    int n;
    n = 0;
    while (phase !== 2'h0) begin
      @(negedge clk);
      n++;
      if (n > 8) begin
        err_total++;
        test_done();
      end
    end
    v = {exec_nop, 7'h00};
    ce = {3'h0, cycle_end};
    for (int i = 1; i < 4; i++) begin
      @(posedge clk);
      if (i == 1) begin
        test_true <= tt;
      end
      @(negedge clk);
      ce[i] = cycle_end;
      if (i == 1) begin
        v[6:4] = {file_read, read_from_pins, porta_change_clear};
      end
    end
    v[3:0] = {file_write, acc_write, fetch_redirect, tmr0_prescaler_clear};
    cmp({8'h00, v}, {8'h00, exp});
    cmp({12'h000, ce}, 16'h0008);
    cmp({15'h0000, fetch_strobe}, 16'h0001);
  endtask : step
  // ==========================================================================
  // Scenarios
  task automatic test_reset();
    repeat (5) @(posedge clk);
    @(negedge clk);
    cmp({13'h0000, phase, exec_nop}, 16'h0001);
    cmp({8'h00, acc_sum}, 16'h0000);
    @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    step(8'h80, 1'b0);
    $display("test_reset done");
  endtask : test_reset
  task automatic test_byte_ops();
    step(8'h78, 1'b0);
    cmp({15'h0000, dec.dest_file}, 16'h0001);
    step(8'h78, 1'b0);
    step(8'h64, 1'b0);
    step(8'h49, 1'b0);
    $display("test_byte_ops done");
  endtask : test_byte_ops
  task automatic test_lit_bit();
    step(8'h04, 1'b0);
    cmp({8'h00, acc_sum}, 16'h004D);
    cmp({14'h0000, dec.cls}, {14'h0000, decode_pkg::CLS_LITCTL});
    step(8'h48, 1'b0);
    cmp({6'h00, dec.bit_pos, dec.file_addr}, 16'h02A0);
    cmp({14'h0000, dec.cls}, {14'h0000, decode_pkg::CLS_BIT});
    step(8'h42, 1'b1);
    cmp({9'h000, dec.file_addr}, 16'h007F);
    step(8'h80, 1'b0);
    $display("test_lit_bit done");
  endtask : test_lit_bit
  task automatic test_jump();
    step(8'h02, 1'b0);
    cmp({5'h00, dec.lit11}, 16'h07FF);
    step(8'h80, 1'b0);
    step(8'h04, 1'b0);
    step(8'h40, 1'b0);
    $display("test_jump done");
  endtask : test_jump
  task automatic test_mid_reset();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    cmp({12'h000, phase, exec_nop, file_write}, 16'h0002);
    @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    @(negedge clk);
    cmp({14'h0000, phase}, 16'h0001);
    // Rerun from address zero with other datapath levels
    @(posedge clk);
    prescaler_to_timer <= 1'b0;
    acc_in <= 8'hF0;
    @(negedge clk);
    step(8'h78, 1'b0);
    step(8'h78, 1'b0);
    step(8'h64, 1'b0);
    step(8'h48, 1'b0);
    step(8'h04, 1'b0);
    cmp({8'h00, acc_sum}, 16'h002C);
    $display("test_mid_reset done");
  endtask : test_mid_reset
  // ==========================================================================
  // Main sequence
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    test_true = 1'b0;
    prescaler_to_timer = 1'b1;
    acc_in = 8'h11;
    err_total = 0;
    comparisons = 0;
    for (int i = 0; i < 16; i++) begin
      i_mem.rom[i] = PROG[i];
    end
    test_reset();
    test_byte_ops();
    test_lit_bit();
    test_jump();
    test_mid_reset();
    test_done();
  end
endmodule : core_instruction_decode_timing_bench
